/* design/ccc_consts.svh */
// offsets, field positions, reset values and timing counts of the charge cycle controller
// assumes a 20 MHz sys_clk and a byte-addressed register bus, one word per register
//
// Operation
// (R1) Supply rises above lockout: defaults, then accesses
// (R2) Input out of range: input FET off at once
// (R3) Immunity timer must elapse before system start
// (R4) Force-off bit kills input FET; inhibit blocks charging
// (R5) Regulate system node above target, else fully on
// (R6) System target voltage from low nibble
// (R7) Below exit level apply pre-charge current field
// (R8) Pre-charge timeout stops cycle, flags fault
// (R9) Above exit level enter fast charge current
// (R10) Reaching full voltage switches to constant voltage
// (R11) Termination delay held below hysteresis gives done
// (R12) Termination threshold from low current nibble
// (R13) Termination enable and keep bit pick outcome
// (R14) New cycle on recycle, enable or recharge
// (R15) Start only without faults and inhibit
// (R16) Battery sag after done restarts charging itself
// (R17) Auto-recharge only with termination, keep bit clear
// (R18) Battery over-voltage suspends charging, flags fault
// (R19) Recharge trigger needs deglitch interval first
// (R20) Safety timer restarts on cycle or clears
// (R21) Timers count clock, clear when condition drops
// (R22) Charge phase readable as encoded status
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH

// register indexes, byte address is four times the index
`define CCC_IDX_CTRL 6'h01
`define CCC_IDX_CHG 6'h02
`define CCC_IDX_CUR 6'h03
`define CCC_IDX_VBAT 6'h04
`define CCC_IDX_TERM 6'h05
`define CCC_IDX_SYS 6'h07
`define CCC_IDX_STAT 6'h08

// field positions
`define CCC_INH_BIT 3
`define CCC_HIZ_BIT 4
`define CCC_KEEPCV_BIT 0
`define CCC_ENTERM_BIT 4

// reset values
`define CCC_RST_CTRL 8'h00
`define CCC_RST_CHG 8'h10
`define CCC_RST_CUR 8'h03
`define CCC_RST_VBAT 8'h80
`define CCC_RST_TERM 8'h10
`define CCC_RST_SYS 8'h08

// timing
`define CCC_CLK_PERIOD_NS 50
`define CCC_IMMUNITY_US 200
`define CCC_IMMUNITY_CYC ((`CCC_IMMUNITY_US * 1000 + `CCC_CLK_PERIOD_NS - 1) / `CCC_CLK_PERIOD_NS)
`define CCC_PRECHG_HR 1
`define CCC_PRECHG_CYC ((64'd3600000000000 * `CCC_PRECHG_HR) / `CCC_CLK_PERIOD_NS)
`define CCC_TERM_MS 3200
`define CCC_TERM_CYC ((64'd1000000 * `CCC_TERM_MS) / `CCC_CLK_PERIOD_NS)
`define CCC_RECH_MS 200
`define CCC_RECH_CYC ((64'd1000000 * `CCC_RECH_MS) / `CCC_CLK_PERIOD_NS)

`endif

/* design/ccc_pkg.sv */
// types of the charge cycle controller
// assumes the constants header is included by the design files
package ccc_pkg;

  typedef enum logic [2:0] {
    CCC_ST_IDLE = 3'b000,
    CCC_ST_PRE = 3'b001,
    CCC_ST_FAST = 3'b010,
    CCC_ST_CV = 3'b011,
    CCC_ST_DONE = 3'b100
  } ccc_state_t;

  // comparator outputs from the analog side, all active high
  typedef struct packed {
    logic supply_ok;
    logic in_ovp;
    logic in_under_voltage_lockout;
    logic in_above_sys;
    logic batt_below_pre;
    logic batt_at_full;
    logic batt_over;
    logic batt_below_rech;
    logic ichg_below_term;
    logic ichg_below_hys;
    logic ntc_fault;
  } ccc_sense_t;

endpackage

/* design/ccc_timer.sv */
// qualifying timer: counts while run is high, clears when it drops
// assumes run comes from logic on sys_clk
`timescale 1ns/10ps
module ccc_timer #(
  parameter int W = 12,
  parameter logic [W-1:0] LIMIT = '1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // condition and expiry
  input wire logic run,
  output logic done
);
  logic [W-1:0] cnt;
  wire logic [W-1:0] next_cnt = !run ? '0 : (cnt == LIMIT) ? cnt : cnt + 1'b1; // see (R21)

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) cnt <= '0;
    else cnt <= next_cnt;
  end

  assign done = run && (cnt == LIMIT);
endmodule

/* design/ccc_top.sv */
// charge cycle controller: power path gating, charge phases, Avalon-MM registers
// assumes comparator inputs are asynchronous and a master that honours waitrequest
`timescale 1ns/10ps
`include "ccc_consts.svh"
module ccc_top import ccc_pkg::*; #(
  parameter logic [36:0] PRECHG_CYC = 37'(`CCC_PRECHG_CYC),
  parameter logic [25:0] TERM_CYC = 26'(`CCC_TERM_CYC),
  parameter logic [21:0] RECH_CYC = 22'(`CCC_RECH_CYC)
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register bus
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // analog comparators
  input wire ccc_sense_t sense_pin,
  // power stage
  output logic input_pass_fet_on,
  output logic battery_pass_fet_chg_on,
  output logic sys_regulate_mode,
  output logic [5:0] charge_current_code,
  output logic [3:0] term_current_code,
  output logic [3:0] system_target_voltage,
  output logic [5:0] battery_full_voltage,
  // status
  output logic [2:0] charge_phase,
  output logic timeout_fault,
  output logic over_voltage_guard_fault,
  output logic charge_done,
  output logic safety_timer_restart
);
  localparam logic [11:0] IMM_CYC = 12'(`CCC_IMMUNITY_CYC);

  function automatic logic hit(input logic [5:0] a, input logic [5:0] idx);
    return a == {idx[3:0], 2'b00};
  endfunction

  function automatic logic in_charge(input ccc_state_t st);
    return st == CCC_ST_PRE || st == CCC_ST_FAST || st == CCC_ST_CV;
  endfunction

  // comparator synchroniser
  ccc_sense_t sense_meta;
  ccc_sense_t s;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sense_meta <= '0;
      s <= '0;
    end else begin
      sense_meta <= sense_pin;
      s <= sense_meta;
    end
  end

  // registers
  logic [7:0] reg_ctrl;
  logic [7:0] reg_chg;
  logic [7:0] reg_cur;
  logic [7:0] reg_vbat;
  logic [7:0] reg_term;
  logic [7:0] reg_sys;
  ccc_state_t state;
  ccc_state_t next_state;

  wire logic sup_ok = s.supply_ok;
  wire logic wr = write && !waitrequest && byteenable[0];
  wire logic [7:0] wd = writedata[7:0];
  wire logic wr_ctrl = wr && hit(address, `CCC_IDX_CTRL);
  wire logic wr_chg = wr && hit(address, `CCC_IDX_CHG);
  wire logic wr_cur = wr && hit(address, `CCC_IDX_CUR);
  wire logic wr_vbat = wr && hit(address, `CCC_IDX_VBAT);
  wire logic wr_term = wr && hit(address, `CCC_IDX_TERM);
  wire logic wr_sys = wr && hit(address, `CCC_IDX_SYS);

  // below lockout every register sits at its default
  wire logic [7:0] next_ctrl = !sup_ok ? `CCC_RST_CTRL : wr_ctrl ? wd : reg_ctrl; // see (R1)
  wire logic [7:0] next_chg = !sup_ok ? `CCC_RST_CHG : wr_chg ? wd : reg_chg;
  wire logic [7:0] next_cur = !sup_ok ? `CCC_RST_CUR : wr_cur ? wd : reg_cur;
  wire logic [7:0] next_vbat = !sup_ok ? `CCC_RST_VBAT : wr_vbat ? wd : reg_vbat;
  wire logic [7:0] next_term = !sup_ok ? `CCC_RST_TERM : wr_term ? wd : reg_term;
  wire logic [7:0] next_sys = !sup_ok ? `CCC_RST_SYS : wr_sys ? wd : reg_sys;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_ctrl <= `CCC_RST_CTRL;
      reg_chg <= `CCC_RST_CHG;
      reg_cur <= `CCC_RST_CUR;
      reg_vbat <= `CCC_RST_VBAT;
      reg_term <= `CCC_RST_TERM;
      reg_sys <= `CCC_RST_SYS;
    end else begin
      reg_ctrl <= next_ctrl;
      reg_chg <= next_chg;
      reg_cur <= next_cur;
      reg_vbat <= next_vbat;
      reg_term <= next_term;
      reg_sys <= next_sys;
    end
  end

  // read path: status word shows the block's own state
  wire logic [7:0] stat = {1'b0, charge_done, input_pass_fet_on,
                           over_voltage_guard_fault, timeout_fault, charge_phase}; // see (R22)
  wire logic [7:0] rd_byte =
    hit(address, `CCC_IDX_CTRL) ? reg_ctrl :
    hit(address, `CCC_IDX_CHG) ? reg_chg :
    hit(address, `CCC_IDX_CUR) ? reg_cur :
    hit(address, `CCC_IDX_VBAT) ? reg_vbat :
    hit(address, `CCC_IDX_TERM) ? reg_term :
    hit(address, `CCC_IDX_SYS) ? reg_sys :
    hit(address, `CCC_IDX_STAT) ? stat : 8'h00;
  // one wait cycle per access; held off entirely while below lockout
  wire logic next_waitrequest = waitrequest ? !((read || write) && sup_ok) : 1'b1; // see (R1)
  wire logic [31:0] next_readdata = (waitrequest && read) ? {24'h000000, rd_byte} : readdata;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
    end
  end

  // control fields
  wire logic hiz = reg_ctrl[`CCC_HIZ_BIT];
  wire logic inh = reg_ctrl[`CCC_INH_BIT];
  wire logic en_term = reg_term[`CCC_ENTERM_BIT];
  wire logic keep_cv = reg_term[`CCC_KEEPCV_BIT];
  wire logic in_ok = !s.in_ovp && !s.in_under_voltage_lockout;

  // timers
  logic imm_done;
  logic pre_done;
  logic term_done;
  logic rech_done;
  logic term_arm;
  logic in_good_q;

  ccc_timer #(.W(12), .LIMIT(IMM_CYC)) u_imm (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(in_ok), // see (R3)
    .done(imm_done)
  );

  ccc_timer #(.W(37), .LIMIT(PRECHG_CYC)) u_pre (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(state == CCC_ST_PRE), // see (R8)
    .done(pre_done)
  );

  ccc_timer #(.W(26), .LIMIT(TERM_CYC)) u_term (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(term_arm && s.ichg_below_hys), // see (R11)
    .done(term_done)
  );

  ccc_timer #(.W(22), .LIMIT(RECH_CYC)) u_rech (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(state == CCC_ST_DONE && s.batt_below_rech && in_ok), // see (R19)
    .done(rech_done)
  );

  // cycle start and restart events
  wire logic in_good = in_ok && imm_done; // see (R3)
  wire logic recycle = in_good && !in_good_q;
  wire logic inh_clr = wr_ctrl && inh && !wd[`CCC_INH_BIT];
  wire logic hiz_clr = wr_ctrl && hiz && !wd[`CCC_HIZ_BIT];
  wire logic restart_clr = recycle || inh_clr || hiz_clr; // see (R20)
  wire logic auto_ok = en_term && !keep_cv; // see (R17)
  wire logic rech_trig = state == CCC_ST_DONE && rech_done && auto_ok; // see (R16)
  wire logic trig = recycle || inh_clr || rech_trig; // see (R14)
  wire logic gate_ok = !s.ntc_fault && !s.batt_over && !next_ctrl[`CCC_INH_BIT]
                       && (!timeout_fault || restart_clr); // see (R15)
  wire logic start = trig && gate_ok && in_good;
  wire logic abort = !in_good || hiz || inh || s.ntc_fault || s.batt_over; // see (R18)
  wire ccc_state_t start_st = s.batt_below_pre ? CCC_ST_PRE : CCC_ST_FAST;
  wire logic next_term_arm = state == CCC_ST_CV && en_term
                             && (term_arm ? s.ichg_below_hys : s.ichg_below_term); // see (R11)
  wire logic next_timeout = (state == CCC_ST_PRE && pre_done) ? 1'b1 :
                            restart_clr ? 1'b0 : timeout_fault; // see (R8)

  always_comb begin
    next_state = state;
    unique case (state)
      CCC_ST_IDLE: begin
        if (start) next_state = start_st;
      end
      CCC_ST_PRE: begin
        if (abort || pre_done) next_state = CCC_ST_IDLE; // see (R8)
        else if (!s.batt_below_pre) next_state = CCC_ST_FAST; // see (R9)
      end
      CCC_ST_FAST: begin
        if (abort) next_state = CCC_ST_IDLE;
        else if (s.batt_at_full) next_state = CCC_ST_CV; // see (R10)
      end
      CCC_ST_CV: begin
        if (abort) next_state = CCC_ST_IDLE;
        else if (term_done && en_term && !keep_cv) next_state = CCC_ST_DONE; // see (R13)
      end
      CCC_ST_DONE: begin
        if (start) next_state = start_st;
      end
      default: next_state = CCC_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= CCC_ST_IDLE;
      term_arm <= 1'b0;
      in_good_q <= 1'b0;
      timeout_fault <= 1'b0;
    end else begin
      state <= next_state;
      term_arm <= next_term_arm;
      in_good_q <= in_good;
      timeout_fault <= next_timeout;
    end
  end

  // registered outputs
  wire logic [5:0] next_ccode = (state == CCC_ST_PRE) ? {2'h0, reg_cur[3:0]} : reg_chg[5:0];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      input_pass_fet_on <= 1'b0;
      battery_pass_fet_chg_on <= 1'b0;
      sys_regulate_mode <= 1'b0;
      charge_current_code <= 6'h00;
      term_current_code <= 4'h0;
      system_target_voltage <= 4'h0;
      battery_full_voltage <= 6'h00;
      charge_phase <= 3'h0;
      over_voltage_guard_fault <= 1'b0;
      charge_done <= 1'b0;
      safety_timer_restart <= 1'b0;
    end else begin
      input_pass_fet_on <= in_good && !hiz; // see (R2) (R4)
      battery_pass_fet_chg_on <= in_charge(next_state) && !inh; // see (R4)
      sys_regulate_mode <= s.in_above_sys; // see (R5)
      charge_current_code <= next_ccode; // see (R7) (R9)
      term_current_code <= reg_cur[3:0]; // see (R12)
      system_target_voltage <= reg_sys[3:0]; // see (R6)
      battery_full_voltage <= reg_vbat[7:2]; // see (R10)
      charge_phase <= next_state; // see (R22)
      over_voltage_guard_fault <= s.batt_over; // see (R18)
      charge_done <= next_state == CCC_ST_DONE; // see (R11)
      safety_timer_restart <= restart_clr || start; // see (R20)
    end
  end

  // checks
  property p_r1_defaults;
    @(posedge sys_clk) disable iff (!nrst)
      !sup_ok |=> waitrequest && reg_ctrl == `CCC_RST_CTRL && reg_term == `CCC_RST_TERM;
  endproperty
  a_r1_defaults: assert property (p_r1_defaults) else $error("regs not default"); // see (R1)

  property p_r2_off;
    @(posedge sys_clk) disable iff (!nrst)
      !in_ok |=> !input_pass_fet_on;
  endproperty
  a_r2_off: assert property (p_r2_off) else $error("input fet on out of range"); // see (R2)

  property p_r3_imm;
    @(posedge sys_clk) disable iff (!nrst)
      $rose(input_pass_fet_on) |-> $past(imm_done) && $past(in_ok, 2);
  endproperty
  a_r3_imm: assert property (p_r3_imm) else $error("input fet before immunity"); // see (R3)

  property p_r4_force;
    @(posedge sys_clk) disable iff (!nrst)
      (hiz || inh) |=> !($past(hiz) && input_pass_fet_on)
                       && !($past(inh) && battery_pass_fet_chg_on);
  endproperty
  a_r4_force: assert property (p_r4_force) else $error("forced fet still on"); // see (R4)

  property p_r7_pre;
    @(posedge sys_clk) disable iff (!nrst)
      state == CCC_ST_PRE |=> charge_current_code == {2'h0, $past(reg_cur[3:0])};
  endproperty
  a_r7_pre: assert property (p_r7_pre) else $error("wrong pre-charge current"); // see (R7)

  property p_r8_tmo;
    @(posedge sys_clk) disable iff (!nrst)
      state == CCC_ST_PRE && pre_done |=> state == CCC_ST_IDLE && timeout_fault ##1 !charge_done;
  endproperty
  a_r8_tmo: assert property (p_r8_tmo) else $error("pre-charge timeout missed"); // see (R8)

  property p_r13_keep;
    @(posedge sys_clk) disable iff (!nrst)
      state == CCC_ST_CV && (keep_cv || !en_term) |=> state != CCC_ST_DONE;
  endproperty
  a_r13_keep: assert property (p_r13_keep) else $error("terminated while keep"); // see (R13)

  property p_r17_rech;
    @(posedge sys_clk) disable iff (!nrst)
      state == CCC_ST_DONE && !auto_ok && !recycle && !inh_clr |=> state == CCC_ST_DONE;
  endproperty
  a_r17_rech: assert property (p_r17_rech) else $error("recharge not allowed"); // see (R17)

  property p_r18_ovp;
    @(posedge sys_clk) disable iff (!nrst)
      in_charge(state) && s.batt_over |=> state == CCC_ST_IDLE ##1 !battery_pass_fet_chg_on;
  endproperty
  a_r18_ovp: assert property (p_r18_ovp) else $error("charging during over-voltage"); // see (R18)

  property p_r20_restart;
    @(posedge sys_clk) disable iff (!nrst)
      state == CCC_ST_IDLE && next_state != CCC_ST_IDLE |=> safety_timer_restart;
  endproperty
  a_r20_restart: assert property (p_r20_restart) else $error("no safety restart"); // see (R20)

  property p_r6_sys;
    @(posedge sys_clk) disable iff (!nrst)
      system_target_voltage != reg_sys[3:0] |=> system_target_voltage == $past(reg_sys[3:0]);
  endproperty
  a_r6_sys: assert property (p_r6_sys) else $error("system target not following"); // see (R6)

  property p_r11_delay;
    @(posedge sys_clk) disable iff (!nrst)
      state == CCC_ST_CV && !term_done |=> state != CCC_ST_DONE;
  endproperty
  a_r11_delay: assert property (p_r11_delay) else $error("done before delay"); // see (R11)

  property p_r12_term;
    @(posedge sys_clk) disable iff (!nrst)
      term_current_code != reg_cur[3:0] |=> term_current_code == $past(reg_cur[3:0]);
  endproperty
  a_r12_term: assert property (p_r12_term) else $error("term current not following"); // see (R12)

  property p_r15_gate;
    @(posedge sys_clk) disable iff (!nrst)
      !in_charge(state) && (s.ntc_fault || s.batt_over) |=> !in_charge(state);
  endproperty
  a_r15_gate: assert property (p_r15_gate) else $error("cycle started under fault"); // see (R15)
endmodule

/* tb/ccc_top_tb.sv */
// self-checking bench for the charge cycle controller top
// assumes ccc_top with short timer parameters and a 20 MHz sys_clk
`timescale 1ns/10ps
`include "ccc_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module ccc_top_tb import ccc_pkg::*;;
  localparam int PRE_N = 100;
  localparam int TERM_N = 20;
  localparam int RECH_N = 20;
  logic sys_clk, nrst, read, write;
  logic [5:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic waitrequest, input_pass_fet_on, battery_pass_fet_chg_on, sys_regulate_mode;
  logic [5:0] charge_current_code, battery_full_voltage;
  logic [3:0] term_current_code, system_target_voltage;
  logic [2:0] charge_phase;
  logic timeout_fault, over_voltage_guard_fault, charge_done, safety_timer_restart;
  ccc_sense_t sense;
  int errors, check_count, restart_cnt, wait_n, last_k, r0;
  logic [7:0] q, d, cur_v, chg_v;
  logic [5:0] idx [7] = '{`CCC_IDX_CTRL, `CCC_IDX_CHG, `CCC_IDX_CUR, `CCC_IDX_VBAT,
    `CCC_IDX_TERM, `CCC_IDX_SYS, `CCC_IDX_STAT};
  logic [7:0] rv [7] = '{`CCC_RST_CTRL, `CCC_RST_CHG, `CCC_RST_CUR, `CCC_RST_VBAT,
    `CCC_RST_TERM, `CCC_RST_SYS, 8'h00};

  ccc_top #(.PRECHG_CYC(37'(PRE_N)), .TERM_CYC(26'(TERM_N)), .RECH_CYC(22'(RECH_N))) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sense_pin(sense), .input_pass_fet_on(input_pass_fet_on),
    .battery_pass_fet_chg_on(battery_pass_fet_chg_on), .sys_regulate_mode(sys_regulate_mode),
    .charge_current_code(charge_current_code), .term_current_code(term_current_code),
    .system_target_voltage(system_target_voltage), .battery_full_voltage(battery_full_voltage),
    .charge_phase(charge_phase), .timeout_fault(timeout_fault),
    .over_voltage_guard_fault(over_voltage_guard_fault), .charge_done(charge_done),
    .safety_timer_restart(safety_timer_restart));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (safety_timer_restart === 1'b1) restart_cnt++;
  end

  function logic [5:0] ad(logic [5:0] i);
    return i << 2;
  endfunction

  // expected drive code: pre-charge uses the low nibble of the current register
  function logic [5:0] exp_code(logic pre, logic [7:0] cur, logic [7:0] chg);
    return pre ? {2'b00, cur[3:0]} : chg[5:0];
  endfunction

  function logic [2:0] pick(int s);
    case (s)
      0: return charge_phase;
      1: return {2'b00, input_pass_fet_on};
      2: return {2'b00, timeout_fault};
      default: return {2'b00, sys_regulate_mode};
    endcase
  endfunction

  task stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one Avalon access, held until waitrequest is sampled low
  task bus(input logic wr, input logic [5:0] a, input logic [7:0] dv, output logic [7:0] qv);
    last_k = 0;
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, dv};
    do begin
      @(posedge sys_clk);
      last_k++;
    end while (waitrequest !== 1'b0 && last_k < 200);
    qv = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    if (last_k >= 200) begin
      errors++;
      stop_test();
    end
    @(posedge sys_clk);
  endtask

  task wr(input logic [5:0] i, input logic [7:0] dv);
    bus(1'b1, ad(i), dv, q);
    tick(2);
  endtask

  task wait_on(input int sel, input logic [2:0] v, input int bound);
    wait_n = 0;
    while (pick(sel) !== v && wait_n < bound) begin
      @(posedge sys_clk);
      wait_n++;
    end
    if (wait_n >= bound) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, pick(sel), v);
      stop_test();
    end
  endtask

  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    byteenable = 4'h1;
    sense = '0;
    sense.in_under_voltage_lockout = 1'b1;
    errors = 0;
    check_count = 0;
    restart_cnt = 0;
    void'($urandom(90037));
    tick(2);
    nrst <= 1'b1;
    @(posedge sys_clk);
    // access waits while the supply is below lockout
    fork
      bus(1'b0, ad(`CCC_IDX_SYS), 8'h00, q);
      begin
        tick(10);
        sense.supply_ok <= 1'b1;
      end
    join
    `CHK(last_k >= 10, 1'b1)
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ad(idx[i]), 8'h00, q);
      `CHK(q, rv[i])
    end
    bus(1'b0, 6'h18, 8'h00, q);
    `CHK(q, 8'h00)
    wr(`CCC_IDX_SYS, 8'h05);
    sense.supply_ok <= 1'b0;
    tick(5);
    sense.supply_ok <= 1'b1;
    tick(4);
    `CHK(system_target_voltage, 4'h8)
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      wr(`CCC_IDX_SYS, d);
      `CHK(system_target_voltage, d[3:0])
      wr(`CCC_IDX_VBAT, d ^ 8'h5a);
      `CHK(battery_full_voltage, 6'((d ^ 8'h5a) >> 2))
      wr(`CCC_IDX_CUR, d + 8'h01);
      `CHK(term_current_code, 4'(d + 8'h01))
    end
    cur_v = d + 8'h01;
    byteenable <= 4'h0;
    wr(`CCC_IDX_SYS, ~d);
    byteenable <= 4'h1;
    `CHK(system_target_voltage, d[3:0])
    chg_v = 8'($urandom);
    wr(`CCC_IDX_CHG, chg_v);
    // input good: immunity, recycle start into pre-charge, then timeout
    sense.batt_below_pre <= 1'b1;
    r0 = restart_cnt;
    sense.in_under_voltage_lockout <= 1'b0;
    wait_on(1, 3'h1, 5000);
    `CHK(wait_n >= 4000 && wait_n <= 4010, 1'b1)
    wait_on(0, 3'h1, 50);
    tick(2);
    `CHK(charge_current_code, exp_code(1'b1, cur_v, chg_v))
    `CHK(restart_cnt > r0, 1'b1)
    wait_on(2, 3'h1, PRE_N + 50);
    tick(1);
    `CHK(charge_phase, 3'h0)
    sense.in_ovp <= 1'b1;
    tick(4);
    `CHK(input_pass_fet_on, 1'b0)
    sense.in_ovp <= 1'b0;
    tick(2000);
    `CHK(input_pass_fet_on, 1'b0)
    sense.in_ovp <= 1'b1;
    tick(5);
    sense.in_ovp <= 1'b0;
    wait_on(1, 3'h1, 5000);
    `CHK(wait_n >= 4000, 1'b1)
    wait_on(0, 3'h1, 50);
    `CHK(timeout_fault, 1'b0)
    sense.batt_below_pre <= 1'b0;
    wait_on(0, 3'h2, 20);
    tick(2);
    `CHK(charge_current_code, exp_code(1'b0, cur_v, chg_v))
    `CHK(battery_pass_fet_chg_on, 1'b1)
    wr(`CCC_IDX_CTRL, 8'h08);
    `CHK(battery_pass_fet_chg_on, 1'b0)
    `CHK(input_pass_fet_on, 1'b1)
    wr(`CCC_IDX_CTRL, 8'h10);
    `CHK(input_pass_fet_on, 1'b0)
    r0 = restart_cnt;
    wr(`CCC_IDX_CTRL, 8'h00);
    `CHK(restart_cnt > r0, 1'b1)
    wait_on(1, 3'h1, 20);
    wr(`CCC_IDX_CTRL, 8'h08);
    sense.ntc_fault <= 1'b1;
    wr(`CCC_IDX_CTRL, 8'h00);
    tick(5);
    `CHK(charge_phase, 3'h0)
    sense.ntc_fault <= 1'b0;
    wr(`CCC_IDX_CTRL, 8'h08);
    wr(`CCC_IDX_CTRL, 8'h00);
    wait_on(0, 3'h2, 20);
    sense.in_above_sys <= 1'b1;
    wait_on(3, 3'h1, 10);
    sense.in_above_sys <= 1'b0;
    wait_on(3, 3'h0, 10);
    // constant voltage, termination delay cleared by a hysteresis break
    sense.batt_at_full <= 1'b1;
    wait_on(0, 3'h3, 20);
    sense.ichg_below_term <= 1'b1;
    sense.ichg_below_hys <= 1'b1;
    tick(10);
    sense.ichg_below_hys <= 1'b0;
    tick(30);
    `CHK(charge_phase, 3'h3)
    sense.ichg_below_hys <= 1'b1;
    wait_on(0, 3'h4, 100);
    `CHK(wait_n >= TERM_N, 1'b1)
    `CHK(charge_done, 1'b1)
    bus(1'b0, ad(`CCC_IDX_STAT), 8'h00, q);
    `CHK({q[6], q[2:0]}, 4'hc)
    sense.batt_at_full <= 1'b0;
    sense.ichg_below_term <= 1'b0;
    sense.ichg_below_hys <= 1'b0;
    sense.batt_below_rech <= 1'b1;
    tick(10);
    sense.batt_below_rech <= 1'b0;
    tick(30);
    `CHK(charge_phase, 3'h4)
    sense.batt_below_rech <= 1'b1;
    wait_on(0, 3'h2, 100);
    `CHK(wait_n >= RECH_N, 1'b1)
    sense.batt_below_rech <= 1'b0;
    // keep-CV and termination-off both stay charging
    wr(`CCC_IDX_TERM, 8'h11);
    sense.batt_at_full <= 1'b1;
    sense.ichg_below_term <= 1'b1;
    sense.ichg_below_hys <= 1'b1;
    wait_on(0, 3'h3, 20);
    tick(60);
    `CHK({charge_done, charge_phase}, 4'h3)
    wr(`CCC_IDX_TERM, 8'h00);
    tick(60);
    `CHK({charge_done, charge_phase}, 4'h3)
    wr(`CCC_IDX_TERM, 8'h10);
    wait_on(0, 3'h4, 100);
    wr(`CCC_IDX_TERM, 8'h11);
    sense.batt_at_full <= 1'b0;
    sense.ichg_below_term <= 1'b0;
    sense.ichg_below_hys <= 1'b0;
    sense.batt_below_rech <= 1'b1;
    tick(60);
    `CHK(charge_phase, 3'h4)
    wr(`CCC_IDX_TERM, 8'h10);
    wait_on(0, 3'h2, 100);
    sense.batt_over <= 1'b1;
    wait_on(0, 3'h0, 10);
    tick(2);
    `CHK(over_voltage_guard_fault, 1'b1)
    sense.batt_over <= 1'b0;
    tick(5);
    stop_test();
  end
endmodule
